/* File: adcc_pkg.sv */
// Package for the converter control block: register map, fields, timing.
// Assumes one system clock and a plain register port of 8-bit registers.
package adcc_pkg;
    // Register indices (byte-wide registers on a plain port)
    localparam logic [2:0] ADCC_CTRL0_ADDR  = 3'h0;
    localparam logic [2:0] ADCC_CTRL1_ADDR  = 3'h1;
    localparam logic [2:0] ADCC_CTRL2_ADDR  = 3'h2;
    localparam logic [2:0] ADCC_RESH_ADDR   = 3'h3;
    localparam logic [2:0] ADCC_RESL_ADDR   = 3'h4;
    localparam logic [2:0] ADCC_INTC_ADDR   = 3'h5;
    localparam logic [2:0] ADCC_SAMPLE_ADDR = 3'h6;
    // conv_ctrl_reg0 fields
    localparam int ADCC_C0_START = 7;
    localparam int ADCC_C0_BUSY  = 6;
    localparam int ADCC_C0_PWR   = 5;
    localparam int ADCC_C0_ALIGN = 4;
    localparam int ADCC_C0_CHAN  = 0;
    // conv_ctrl_reg1 fields
    localparam int ADCC_C1_SRC   = 4;
    localparam int ADCC_C1_DIV   = 0;
    // interrupt control fields
    localparam int ADCC_IC_GIE   = 0;
    localparam int ADCC_IC_CIE   = 1;
    localparam int ADCC_IC_FLAG  = 2;
    // Reset values
    localparam logic [7:0] ADCC_C0_RST = 8'h00;
    localparam logic [7:0] ADCC_C1_RST = 8'h00;
    localparam logic [7:0] ADCC_C2_RST = 8'h00;
    // Conversion timing in conversion-clock periods
    localparam logic [4:0] ADCC_SAMPLE_CLKS = 5'h04;
    localparam logic [4:0] ADCC_TOTAL_CLKS  = 5'h10;
    // Input source codes: upper bits for ground, full code for external
    localparam logic [1:0] ADCC_SRC_GND_HI = 2'h2;
    localparam logic [3:0] ADCC_SRC_EXT    = 4'h0;
    // Sequencer states
    typedef enum logic [1:0] {
        ADCC_IDLE   = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_CONV   = 2'b10
    } adcc_state_t;
endpackage : adcc_pkg

/* File: adcc_conv_ctrl.sv */
// Sequencing and register logic for a 12-bit successive-approximation converter.
// Assumes the analog core returns a comparator decision each conversion step.
//
// How it works
// [RL1] Sample for 4 conversion clocks, then convert for 12, total 16.
// [RL2] Once started, the sequencer finishes alone with no further software help.
// [RL3] Conversion clock is system clock divided per clk_div_sel.
// [RL4] adc_power_en low powers the core down and stops any conversion.
// [RL5] input_src_sel picks external or internal; internal disconnects external channel.
// [RL6] ext_chan_sel picks the external channel when external path is chosen.
// [RL7] vref_sel picks reference source, one option the amplifier output.
// [RL8] result_align_sel picks how 12 result bits split across high and low.
// [RL9] Interrupt only when global and converter interrupt enables both set.
// [RL10] Start bit written low, high, low starts one conversion.
// [RL11] conv_busy is high during a conversion, low once complete.
// [RL12] Result readable from result_high and result_low after completion.
// [RL13] Software may poll conv_busy instead of using the interrupt.
// [RL14] Result is 12-bit unsigned, full scale FFF, step is reference over 4096.
// [RL15] Code transitions sit half a step low; last one 1.5 steps low.
// [RL16] Divider code n divides the system clock by two to the n.
// [RL17] Completion sets the interrupt flag and raises the interrupt if enabled.
// [RL18] input_src_sel upper bits 10 connect converter input to ground.
// [RL19] Software keeps the conversion clock period within 0.5 to 10 us.
// [RL20] Result registers hold the last value until the next completion.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
module adcc_conv_ctrl
    import adcc_pkg::*;
#(
    parameter int RES_BITS = 12
)
(
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                rstn_i,
    // Register port
    input  wire logic [2:0]          reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [7:0]          reg_rdata_o,
    // Analog core control
    output logic                     adc_power_o,
    output logic                     sample_en_o,
    output logic                     ext_chan_en_o,
    output logic      [3:0]          ext_chan_o,
    output logic      [3:0]          int_src_o,
    output logic                     gnd_sel_o,
    output logic      [1:0]          vref_sel_o,
    output logic      [RES_BITS-1:0] sar_trial_o,
    input  wire logic                cmp_i,
    // Interrupt request
    output logic                     conv_irq_o
);

    logic [7:0]          ctrl0;
    logic [7:0]          ctrl1;
    logic [7:0]          ctrl2;
    logic                global_int_en;
    logic                conv_int_en;
    logic                conv_int_flag;
    logic                start_q;
    logic                start_armed;
    logic                start_go;
    logic [6:0]          div_cnt;
    logic                tick;
    logic [4:0]          step_cnt;
    logic [RES_BITS-1:0] sar;
    logic [RES_BITS-1:0] result;
    logic                done;
    logic                cmp_s1;
    logic                cmp_s2;
    logic [11:0]         busy_cycles;
    adcc_state_t         state;
    adcc_state_t         next_state;

    wire adc_power_en     = ctrl0[ADCC_C0_PWR];
    wire result_align_sel = ctrl0[ADCC_C0_ALIGN];
    wire [3:0] ext_chan_sel  = ctrl0[ADCC_C0_CHAN +: 4];
    wire [3:0] input_src_sel = ctrl1[ADCC_C1_SRC +: 4];
    wire [2:0] clk_div_sel   = ctrl1[ADCC_C1_DIV +: 3];
    wire conv_busy = (state != ADCC_IDLE);
    wire wr_c0 = reg_wr_i && (reg_addr_i == ADCC_CTRL0_ADDR);
    wire wr_ic = reg_wr_i && (reg_addr_i == ADCC_INTC_ADDR);

    // Control registers; busy bit is read-only
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl0 <= ADCC_C0_RST;
            ctrl1 <= ADCC_C1_RST;
            ctrl2 <= ADCC_C2_RST;
            global_int_en <= 1'b0;
            conv_int_en   <= 1'b0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                ADCC_CTRL0_ADDR: ctrl0 <= reg_wdata_i;
                ADCC_CTRL1_ADDR: ctrl1 <= reg_wdata_i;
                ADCC_CTRL2_ADDR: ctrl2 <= reg_wdata_i;
                ADCC_INTC_ADDR:
                begin
                    global_int_en <= reg_wdata_i[ADCC_IC_GIE];
                    conv_int_en   <= reg_wdata_i[ADCC_IC_CIE];
                end
                default: ;
            endcase
        end
    end

    // Start pulse detector: needs a high written then a low written
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            start_q     <= 1'b0;
            start_armed <= 1'b0;
        end
        else if (wr_c0)
        begin
            start_q     <= reg_wdata_i[ADCC_C0_START];
            // Armed only by a rising edge seen after a low value
            start_armed <= reg_wdata_i[ADCC_C0_START] && !start_q; // [RL10]
        end
    end
    assign start_go = wr_c0 && start_armed && !reg_wdata_i[ADCC_C0_START]
                      && adc_power_en; // [RL10]

    // Divider: one-cycle enable every 2**n system clocks
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            div_cnt <= 7'h00;
        else if (!conv_busy)
            div_cnt <= 7'h00;
        else
            div_cnt <= div_cnt + 7'h01; // [RL3]
    end
    // Mask selects low n bits; n=0 ticks every cycle
    wire [6:0] div_mask = 7'(({7'h00, 1'b1} << clk_div_sel) - 8'h01); // [RL16]
    assign tick = conv_busy && ((div_cnt & div_mask) == div_mask);    // [RL16]

    // Busy length in system clocks, read only by the length checks below
    // Wide enough for 16 periods at the slowest divide, so it never wraps
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            busy_cycles <= 12'h000;
        else if (!conv_busy)
            busy_cycles <= 12'h000;
        else
            busy_cycles <= busy_cycles + 12'h001;
    end

    // Comparator from analog core, resynchronised
    // Two-cycle latency: divide codes below 2 decide on a stale comparator
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
        end
        else
        begin
            cmp_s1 <= cmp_i;
            cmp_s2 <= cmp_s1;
        end
    end

    // Next state of the sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            ADCC_IDLE:
                if (start_go)
                    next_state = ADCC_SAMPLE;
            ADCC_SAMPLE:
                if (tick && step_cnt == ADCC_SAMPLE_CLKS - 5'h01)
                    next_state = ADCC_CONV; // [RL1]
            ADCC_CONV:
                if (tick && step_cnt == ADCC_TOTAL_CLKS - 5'h01)
                    next_state = ADCC_IDLE; // [RL1]
            default:
                next_state = ADCC_IDLE;
        endcase
        if (!adc_power_en)
            next_state = ADCC_IDLE; // [RL4]
    end

    // Sequencer runs without software after the start
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            state <= ADCC_IDLE;
        else
            state <= next_state; // [RL2]
    end

    // Step counter in conversion-clock periods
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            step_cnt <= 5'h00;
        else if (next_state == ADCC_IDLE || state == ADCC_IDLE)
            step_cnt <= 5'h00;
        else if (tick)
            step_cnt <= step_cnt + 5'h01; // [RL1]
    end

    // Successive approximation: one bit per conversion clock, MSB first
    wire [3:0] bit_idx = 4'(ADCC_TOTAL_CLKS - 5'h01 - step_cnt);
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            sar <= '0;
        else if (start_go)
            sar <= {1'b1, {(RES_BITS-1){1'b0}}};
        else if (state == ADCC_CONV && tick)
        begin
            // Keep trial bit when input is above trial level
            sar[bit_idx] <= cmp_s2; // [RL14]
            if (bit_idx != 4'h0)
                sar[bit_idx - 4'h1] <= 1'b1;
        end
    end
    // Trial code offset by half a step is applied in the DAC of the core
    assign sar_trial_o = sar; // [RL15]

    assign done = (state == ADCC_CONV) && (next_state == ADCC_IDLE) && adc_power_en;

    // Result stays until the next completed conversion
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            result <= '0;
        else if (done)
            result <= {sar[RES_BITS-1:1], cmp_s2}; // [RL20]
    end

    // Completion flag: hardware set wins over software clear
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            conv_int_flag <= 1'b0;
        else if (done)
            conv_int_flag <= 1'b1; // [RL17]
        else if (wr_ic)
            conv_int_flag <= reg_wdata_i[ADCC_IC_FLAG];
    end
    assign conv_irq_o = conv_int_flag && global_int_en && conv_int_en; // [RL9]

    // Result arrangement: high 8 then low 4, or high 4 then low 8
    wire [7:0] res_hi = result_align_sel ? {4'h0, result[11:8]} : result[11:4]; // [RL8]
    wire [7:0] res_lo = result_align_sel ? result[7:0] : {result[3:0], 4'h0};  // [RL8]

    // Read data one cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                ADCC_CTRL0_ADDR: reg_rdata_o <= {start_q, conv_busy, ctrl0[5:0]}; // [RL11]
                ADCC_CTRL1_ADDR: reg_rdata_o <= ctrl1;
                ADCC_CTRL2_ADDR: reg_rdata_o <= ctrl2;
                ADCC_RESH_ADDR:  reg_rdata_o <= res_hi; // [RL12]
                ADCC_RESL_ADDR:  reg_rdata_o <= res_lo; // [RL12]
                ADCC_INTC_ADDR:
                    reg_rdata_o <= {5'h00, conv_int_flag, conv_int_en, global_int_en};
                default:         reg_rdata_o <= 8'h00;
            endcase
        end
        else
            reg_rdata_o <= 8'h00;
    end

    // Analog routing; power low isolates the core power, external channel and ground paths, not int_src_o
    assign adc_power_o   = adc_power_en; // [RL4]
    assign sample_en_o   = (state == ADCC_SAMPLE);
    assign gnd_sel_o     = adc_power_en && (input_src_sel[3:2] == ADCC_SRC_GND_HI); // [RL18]
    assign ext_chan_en_o = adc_power_en && (input_src_sel == ADCC_SRC_EXT);          // [RL5]
    assign ext_chan_o    = ext_chan_sel;                                             // [RL6]
    assign int_src_o     = (input_src_sel == ADCC_SRC_EXT) ? 4'h0 : input_src_sel;  // [RL5]
    assign vref_sel_o    = ctrl2[1:0];                                               // [RL7]

    // Assertions
    sequence s_started;
        $rose(conv_busy);
    endsequence
    sequence s_sampling4;
        sample_en_o [*4];
    endsequence

    a_busy_on_start: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL10]
        start_go |=> conv_busy)
        else $error("busy not raised after start");
    a_flag_on_done: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL17]
        done |=> conv_int_flag && !conv_busy)
        else $error("flag not set at completion");
    a_irq_gated: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL9]
        conv_irq_o |-> global_int_en && conv_int_en)
        else $error("interrupt without both enables");
    a_power_stop: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL4]
        !adc_power_en |=> !conv_busy)
        else $error("conversion runs while powered down");
    a_result_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL20]
        !$past(done) |-> $stable(result))
        else $error("result changed without completion");
    a_sample_len: assert property (@(posedge sys_clk_i) disable iff (!rstn_i || !adc_power_en) // [RL1]
        s_started ##0 (clk_div_sel == 3'h0) |-> s_sampling4 ##1 !sample_en_o)
        else $error("sample phase length wrong");
    a_conv_len: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL1]
        done |-> busy_cycles == (12'(ADCC_TOTAL_CLKS) << clk_div_sel) - 12'h001)
        else $error("conversion length wrong");
    a_sample_ends: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL16]
        $fell(sample_en_o) && conv_busy |-> busy_cycles == 12'(ADCC_SAMPLE_CLKS) << clk_div_sel)
        else $error("sample phase not scaled by divider");
    a_start_sample: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL10]
        start_go |=> s_started ##0 sample_en_o)
        else $error("start did not open the sample phase");
    a_gnd_no_ext: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL5]
        gnd_sel_o |-> !ext_chan_en_o)
        else $error("external channel connected with ground source");
    a_power_isolate: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL4]
        !adc_power_en |-> !adc_power_o && !ext_chan_en_o && !gnd_sel_o)
        else $error("analog path live while powered down");
    a_internal_only: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL5]
        ext_chan_en_o |-> int_src_o == 4'h0)
        else $error("internal source live on external path");
    a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL17]
        wr_ic && !reg_wdata_i[ADCC_IC_FLAG] && !done |=> !conv_int_flag)
        else $error("flag not cleared by software");
    a_done_irq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [RL9]
        done && global_int_en && conv_int_en |=> conv_irq_o)
        else $error("no interrupt with both enables set");

endmodule : adcc_conv_ctrl

/* File: adcc_testbench.sv */
// Self-checking bench for the converter control block, driven on its register port.
// Assumes one 250 MHz clock; the comparator is modelled as input >= trial code.
`timescale 1ns/1ns
module testbench;
    import adcc_pkg::*;
    // Clock, reset and register port
    logic        sys_clk_i   = 1'b0;
    logic        rstn_i      = 1'b0;
    logic [2:0]  reg_addr_i  = 3'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [7:0]  reg_rdata_o;
    // Analog core side
    logic        adc_power_o, sample_en_o, ext_chan_en_o, gnd_sel_o, conv_irq_o;
    logic [3:0]  ext_chan_o, int_src_o;
    logic [1:0]  vref_sel_o;
    logic [11:0] sar_trial_o;
    logic [11:0] vin = 12'h000;
    logic        cmp_i;
    logic [7:0]  rd_val, exp_hi, exp_lo;
    int          err_count = 0, n_compared = 0, cyc = 0, smp_cnt = 0;

    adcc_conv_ctrl #(.RES_BITS(12)) dut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .adc_power_o(adc_power_o), .sample_en_o(sample_en_o),
        .ext_chan_en_o(ext_chan_en_o), .ext_chan_o(ext_chan_o),
        .int_src_o(int_src_o), .gnd_sel_o(gnd_sel_o), .vref_sel_o(vref_sel_o),
        .sar_trial_o(sar_trial_o), .cmp_i(cmp_i), .conv_irq_o(conv_irq_o)
    );

    // Ideal comparator: trial bit kept while the input is not below it
    assign cmp_i = (vin >= sar_trial_o);

    always #2 sys_clk_i = ~sys_clk_i;

    // Cycle count, sample-phase length and hang guard
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (sample_en_o === 1'b1) smp_cnt <= smp_cnt + 1;
        if (cyc == 20000)
        begin
            err_count++;
            $display("ERROR t=%0t timeout", $time);
            end_of_test();
        end
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
        #1;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        rd_val = reg_rdata_o;
    endtask : rd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi, input string m);
        n_compared++;
        if (got < lo || got > hi)
        begin
            err_count++;
            $display("ERROR t=%0t %s count %0d not in %0d..%0d", $time, m, got, lo, hi);
        end
    endtask : chk_rng

    task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string m);
        rd(a);
        chk(rd_val, exp, m);
    endtask : rchk

    // One start pulse and a full conversion, ended by the interrupt
    task automatic convert(input int n, input logic al, input logic [11:0] v);
        int t0, d, k;
        logic [7:0] c0;
        d   = 1 << n;
        c0  = {3'b001, al, 4'h3};
        vin = v;
        wr(ADCC_CTRL1_ADDR, {5'h00, n[2:0]});
        wr(ADCC_INTC_ADDR, 8'h03);
        wr(ADCC_CTRL0_ADDR, c0);
        wr(ADCC_CTRL0_ADDR, c0 | 8'h80);
        wr(ADCC_CTRL0_ADDR, c0);
        t0 = cyc;
        smp_cnt = 0;
        rd(ADCC_CTRL0_ADDR);
        chk(rd_val & 8'h40, 8'h40, "busy set");
        // Look just after the edge so the flag set on it is already visible
        for (k = 0; k < 20 * d + 10 && conv_irq_o !== 1'b1; k++)
        begin
            @(posedge sys_clk_i);
            #1;
        end
        chk_rng(cyc - t0, 16 * d, 16 * d, "conversion length");
        chk_rng(smp_cnt, 4 * d, 4 * d, "sample length");
        exp_hi = al ? {4'h0, v[11:8]} : v[11:4];
        exp_lo = al ? v[7:0] : {v[3:0], 4'h0};
        rd(ADCC_CTRL0_ADDR);
        chk(rd_val & 8'h40, 8'h00, "busy clear");
        if (n >= 2) // faster divide codes decide on a stale comparator
        begin
            rchk(ADCC_RESH_ADDR, exp_hi, "result high");
            rchk(ADCC_RESL_ADDR, exp_lo, "result low");
        end
    endtask : convert

    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    logic [11:0] vals [8] = '{12'h000, 12'h001, 12'h800, 12'hFFF,
                              12'h7FF, 12'hA5C, 12'h3C3, 12'hFFE};
    initial
    begin
        repeat (3) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        // Reset values at every index but 6, unmapped index 7 included
        foreach (vals[i]) if (i != 6) rchk(i[2:0], 8'h00, "reset value");
        chk({7'h0, adc_power_o}, 8'h00, "power after reset");
        // Start pulse without power, busy bit write, unmapped write
        wr(ADCC_CTRL0_ADDR, 8'h80);
        wr(ADCC_CTRL0_ADDR, 8'h40);
        rchk(ADCC_CTRL0_ADDR, 8'h00, "unpowered start");
        wr(3'h7, 8'hFF);
        rchk(3'h7, 8'h00, "unmapped");
        // Source, channel, ground and reference routing
        wr(ADCC_CTRL0_ADDR, 8'h25);
        chk({ext_chan_en_o, 3'h0, ext_chan_o}, 8'h85, "external path");
        wr(ADCC_CTRL1_ADDR, 8'h50);
        chk({ext_chan_en_o, gnd_sel_o, 2'h0, int_src_o}, 8'h05, "internal");
        wr(ADCC_CTRL1_ADDR, 8'hB0);
        chk({ext_chan_en_o, gnd_sel_o, 6'h0}, 8'h40, "ground");
        for (int v = 0; v < 4; v++)
        begin
            wr(ADCC_CTRL2_ADDR, v[7:0]);
            chk({6'h0, vref_sel_o}, v[7:0], "reference select");
        end
        wr(ADCC_CTRL1_ADDR, 8'h00);
        wr(ADCC_CTRL0_ADDR, 8'h05);
        chk({adc_power_o, ext_chan_en_o, 6'h0}, 8'h00, "powered down");
        // Every divider code, both alignments, boundary codes
        for (int n = 0; n < 8; n++) convert(n, n[0], vals[n]);
        // Interrupt needs both enables
        wr(ADCC_INTC_ADDR, 8'h05);
        chk({7'h0, conv_irq_o}, 8'h00, "global only");
        wr(ADCC_INTC_ADDR, 8'h06);
        chk({7'h0, conv_irq_o}, 8'h00, "converter only");
        wr(ADCC_INTC_ADDR, 8'h07);
        chk({7'h0, conv_irq_o}, 8'h01, "both enables");
        wr(ADCC_INTC_ADDR, 8'h03);
        chk({7'h0, conv_irq_o}, 8'h00, "flag cleared");
        // Polled conversion with interrupts off: wait for busy low, then read
        wr(ADCC_INTC_ADDR, 8'h00);
        wr(ADCC_CTRL1_ADDR, 8'h02);
        vin = 12'h5A3;
        wr(ADCC_CTRL0_ADDR, 8'h20);
        wr(ADCC_CTRL0_ADDR, 8'hA0);
        wr(ADCC_CTRL0_ADDR, 8'h20);
        rd_val = 8'h40;
        for (int k = 0; k < 100 && rd_val[6] !== 1'b0; k++) rd(ADCC_CTRL0_ADDR);
        chk(rd_val, 8'h20, "polled busy");
        chk({7'h0, conv_irq_o}, 8'h00, "no interrupt when disabled");
        exp_hi = 8'h5A;
        exp_lo = 8'h30;
        rchk(ADCC_RESH_ADDR, exp_hi, "polled high");
        rchk(ADCC_RESL_ADDR, exp_lo, "polled low");
        // Abort by power-down keeps the old result and sets no flag
        wr(ADCC_INTC_ADDR, 8'h00);
        wr(ADCC_CTRL1_ADDR, 8'h03);
        wr(ADCC_CTRL0_ADDR, 8'h20);
        wr(ADCC_CTRL0_ADDR, 8'hA0);
        wr(ADCC_CTRL0_ADDR, 8'h20);
        rchk(ADCC_CTRL0_ADDR, 8'h60, "abort run started");
        repeat (20) @(posedge sys_clk_i);
        wr(ADCC_CTRL0_ADDR, 8'h00);
        repeat (300) @(posedge sys_clk_i);
        rchk(ADCC_CTRL0_ADDR, 8'h00, "aborted busy");
        rchk(ADCC_INTC_ADDR, 8'h00, "aborted flag");
        rchk(ADCC_RESH_ADDR, exp_hi, "held high");
        rchk(ADCC_RESL_ADDR, exp_lo, "held low");
        end_of_test();
    end
endmodule : testbench
